// ===== rtl/nv_cfg_pkg.sv
package nv_cfg_pkg;

  localparam logic [11:0] NV_STATE_OFF = 12'hB00;
  localparam logic [11:0] NV_ERR_OFF   = 12'hB01;
  localparam logic [11:0] NV_CTRL1_OFF = 12'hB02;
  localparam logic [11:0] NV_CTRL2_OFF = 12'hB03;
  localparam logic [11:0] PIN_SEL_OFF  = 12'h232;
  localparam logic [11:0] SEG_BASE_OFF = 12'hA00;
  localparam logic [11:0] SEG_LAST_OFF = 12'hA16;
  localparam logic [11:0] COMMIT_OFF   = 12'h00F;

  localparam int BUSY_BIT     = 0;
  localparam int ERR_BIT      = 0;
  localparam int WR_EN_BIT    = 0;
  localparam int SOFT_RST_BIT = 1;
  localparam int STORE_BIT    = 0;
  localparam int PIN_SEL_BIT  = 4;
  localparam int COMMIT_BIT   = 0;

  localparam int SEG_COUNT = 23;

  // Segment byte 0: bit 7 clear means count-1, set means opcode
  localparam logic [7:0] OP_COMMIT = 8'h80;
  localparam logic [7:0] OP_END    = 8'hFF;

  localparam logic WR_EN_RESET   = 1'b0;
  localparam logic PIN_SEL_RESET = 1'b0;

  // Copy 0x000..0x07F, then commit, then end
  localparam logic [SEG_COUNT*8-1:0] SEG_RESET = {{18{8'hFF}}, 8'hFF, 8'h80, 8'h00, 8'h00, 8'h7F};

  typedef struct packed {
    logic [11:0] addr;
    logic        we;
    logic [7:0]  wdata;
  } bank_req_t;

  typedef enum logic [2:0] {
    X_IDLE = 3'b000,
    X_SEG  = 3'b001,
    X_XFER = 3'b010,
    X_CAP  = 3'b011,
    X_SUM  = 3'b100
  } xfer_state_t;

endpackage

// ===== rtl/nv_xfer_engine.sv
`timescale 1ns/1ps
module nv_xfer_engine #(
  parameter int NV_DEPTH = 256
) (
  input  wire logic                                core_clk,
  input  wire logic                                reset_n,
  input  wire logic                                start_store,
  input  wire logic                                start_load,
  input  wire logic [nv_cfg_pkg::SEG_COUNT*8-1:0]  seg_list,
  input  wire logic [7:0]                          bank_rdata,
  output nv_cfg_pkg::bank_req_t                    bank_req_r,
  output logic                                     busy_r,
  output logic                                     data_err_r,
  output logic                                     commit_r
);

  localparam int PW = $clog2(NV_DEPTH);

  logic [7:0]              nv_mem [NV_DEPTH];
  nv_cfg_pkg::xfer_state_t state_r;
  logic [4:0]              seg_idx_r;
  logic [6:0]              cnt_r;
  logic [11:0]             addr_r;
  logic [PW-1:0]           ptr_r;
  logic [7:0]              sum_r;
  logic                    loading_r;
  logic [7:0]              b0;
  logic [7:0]              b1;
  logic [7:0]              b2;

  function automatic logic [7:0] seg_byte(input logic [4:0] i);
    if (int'(i) < nv_cfg_pkg::SEG_COUNT) begin
      return seg_list[i*8 +: 8];
    end
    return nv_cfg_pkg::OP_END;
  endfunction

  always_comb begin
    b0 = seg_byte(seg_idx_r);
    b1 = seg_byte(seg_idx_r + 5'h01);
    b2 = seg_byte(seg_idx_r + 5'h02);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Segment walker
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      state_r   <= nv_cfg_pkg::X_IDLE;
      seg_idx_r <= 5'h00;
      cnt_r     <= 7'h00;
      addr_r    <= 12'h000;
      ptr_r     <= '0;
      sum_r     <= 8'h00;
      loading_r <= 1'b0;
    end else begin
      case (state_r)
        nv_cfg_pkg::X_IDLE: begin
          if (start_store || start_load) begin
            state_r   <= nv_cfg_pkg::X_SEG;
            loading_r <= start_load;
            seg_idx_r <= 5'h00;
            ptr_r     <= '0;
            sum_r     <= 8'h00;
          end
        end
        nv_cfg_pkg::X_SEG: begin
          if (b0 == nv_cfg_pkg::OP_COMMIT) begin
            seg_idx_r <= seg_idx_r + 5'h01;
          end else if (b0[7]) begin
            state_r <= nv_cfg_pkg::X_SUM;
          end else begin
            cnt_r     <= b0[6:0];
            addr_r    <= {b1[3:0], b2};
            seg_idx_r <= seg_idx_r + 5'h03;
            state_r   <= nv_cfg_pkg::X_XFER;
          end
        end
        nv_cfg_pkg::X_XFER, nv_cfg_pkg::X_CAP: begin
          if (state_r == nv_cfg_pkg::X_XFER && !loading_r) begin
            state_r <= nv_cfg_pkg::X_CAP;
          end else begin
            ptr_r  <= ptr_r + 1'b1;
            sum_r  <= sum_r ^ (loading_r ? nv_mem[ptr_r] : bank_rdata);
            addr_r <= addr_r + 12'h001;
            cnt_r  <= cnt_r - 7'h01;
            state_r <= (cnt_r == 7'h00) ? nv_cfg_pkg::X_SEG : nv_cfg_pkg::X_XFER;
          end
        end
        nv_cfg_pkg::X_SUM: state_r <= nv_cfg_pkg::X_IDLE;
        default:           state_r <= nv_cfg_pkg::X_IDLE;
      endcase
    end
  end

  // Image is data bytes in list order, then one XOR check byte
  always_ff @(posedge core_clk) begin
    if (state_r == nv_cfg_pkg::X_CAP) begin
      nv_mem[ptr_r] <= bank_rdata;
    end else if (state_r == nv_cfg_pkg::X_SUM && !loading_r) begin
      nv_mem[ptr_r] <= sum_r;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      bank_req_r <= '0;
    end else begin
      bank_req_r.we <= 1'b0;
      if (state_r == nv_cfg_pkg::X_XFER) begin
        bank_req_r.addr  <= addr_r;
        bank_req_r.we    <= loading_r;
        bank_req_r.wdata <= nv_mem[ptr_r];
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      busy_r     <= 1'b0;
      data_err_r <= 1'b0;
      commit_r   <= 1'b0;
    end else begin
      busy_r   <= (state_r == nv_cfg_pkg::X_IDLE) ? (start_store | start_load)
                                                  : (state_r != nv_cfg_pkg::X_SUM);
      commit_r <= loading_r && state_r == nv_cfg_pkg::X_SEG && b0 == nv_cfg_pkg::OP_COMMIT;
      if (state_r == nv_cfg_pkg::X_SUM && loading_r) begin
        data_err_r <= (nv_mem[ptr_r] != sum_r);
      end
    end
  end

  a_end_closes_walk: assert property (@(posedge core_clk) disable iff (!reset_n)
    state_r == nv_cfg_pkg::X_SEG && b0 == nv_cfg_pkg::OP_END |=> state_r == nv_cfg_pkg::X_SUM ##1 !busy_r)
    else $error("End opcode did not finish the walk");

endmodule // nv_xfer_engine

// ===== rtl/nv_config_transfer_control.sv
`timescale 1ns/1ps
// What this block does
// - Bit 0 of the transfer state register reads 1 while a store or reload is unfinished and 0 once done.
// - With bit 4 of the status-pin select register set, the busy indication also drives the first status pin.
// - Bit 0 of the error readback register shows 1 after a reload whose data failed its check, else 0.
// - With the boot-select pin low, writing 1 to bit 1 of control one soft-resets and reloads stored settings.
// - Bit 0 of control one gates stores: 0 after reset protects the store, 1 permits stores.
// - Writing 1 to bit 0 of control two starts a store of the buffer bank, and the bit clears itself.
// - The engine walks the 23 segment registers for start addresses, counts, commit and end opcodes.
// - Writing 1 to the commit bit pulses the commit to active registers on the next edge and reads back 0.
module nv_config_transfer_control #(
  parameter int NV_DEPTH = 256
) (
  input  wire logic               core_clk,
  input  wire logic               reset_n,
  input  wire logic [11:0]        reg_addr,
  input  wire logic               reg_wr,
  input  wire logic               reg_rd,
  input  wire logic [7:0]         reg_wdata,
  output logic      [7:0]         reg_rdata_r,
  input  wire logic               boot_sel_pin,
  input  wire logic [7:0]         bank_rdata,
  output nv_cfg_pkg::bank_req_t   bank_req_r,
  output logic                    first_status_out_pin,
  output logic                    soft_reset_r,
  output logic                    commit_pulse_r
);

  logic                                wr_en_r;
  logic                                pin_sel_r;
  logic [nv_cfg_pkg::SEG_COUNT*8-1:0]  seg_r;
  logic                                busy;
  logic                                data_err;
  logic                                eng_commit;
  logic                                store_req;
  logic                                load_req;
  logic                                commit_req;
  logic                                in_seg;
  logic [11:0]                         seg_off;

  ////////////////////////////////////////////////////////////////////////////
  // Write decode
  always_comb begin
    seg_off    = reg_addr - nv_cfg_pkg::SEG_BASE_OFF;
    in_seg     = reg_addr >= nv_cfg_pkg::SEG_BASE_OFF && reg_addr <= nv_cfg_pkg::SEG_LAST_OFF;
    // Store only when unprotected; idle check keeps one walk at a time
    store_req  = reg_wr && reg_addr == nv_cfg_pkg::NV_CTRL2_OFF && reg_wdata[nv_cfg_pkg::STORE_BIT]
                 && wr_en_r && !busy;
    load_req   = reg_wr && reg_addr == nv_cfg_pkg::NV_CTRL1_OFF && reg_wdata[nv_cfg_pkg::SOFT_RST_BIT]
                 && !boot_sel_pin && !busy;
    commit_req = reg_wr && reg_addr == nv_cfg_pkg::COMMIT_OFF && reg_wdata[nv_cfg_pkg::COMMIT_BIT];
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      wr_en_r   <= nv_cfg_pkg::WR_EN_RESET;
      pin_sel_r <= nv_cfg_pkg::PIN_SEL_RESET;
      seg_r     <= nv_cfg_pkg::SEG_RESET;
    end else if (reg_wr) begin
      if (reg_addr == nv_cfg_pkg::NV_CTRL1_OFF) begin
        wr_en_r <= reg_wdata[nv_cfg_pkg::WR_EN_BIT];
      end
      if (reg_addr == nv_cfg_pkg::PIN_SEL_OFF) begin
        pin_sel_r <= reg_wdata[nv_cfg_pkg::PIN_SEL_BIT];
      end
      // List may be edited mid-walk; software should wait for idle
      if (in_seg) begin
        seg_r[seg_off[4:0]*8 +: 8] <= reg_wdata;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Readback; self-clearing bits always read 0
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      reg_rdata_r <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata_r <= 8'h00;
      case (reg_addr)
        nv_cfg_pkg::NV_STATE_OFF: reg_rdata_r[nv_cfg_pkg::BUSY_BIT]   <= busy;
        nv_cfg_pkg::NV_ERR_OFF:   reg_rdata_r[nv_cfg_pkg::ERR_BIT]    <= data_err;
        nv_cfg_pkg::NV_CTRL1_OFF: reg_rdata_r[nv_cfg_pkg::WR_EN_BIT]  <= wr_en_r;
        nv_cfg_pkg::PIN_SEL_OFF:  reg_rdata_r[nv_cfg_pkg::PIN_SEL_BIT] <= pin_sel_r;
        default: begin
          if (in_seg) begin
            reg_rdata_r <= seg_r[seg_off[4:0]*8 +: 8];
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pins and pulses
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      first_status_out_pin <= 1'b0;
      soft_reset_r         <= 1'b0;
      commit_pulse_r       <= 1'b0;
    end else begin
      first_status_out_pin <= pin_sel_r & busy;
      soft_reset_r         <= load_req;
      commit_pulse_r       <= commit_req | eng_commit;
    end
  end

  nv_xfer_engine #(
    .NV_DEPTH (NV_DEPTH)
  ) u_engine (
    .core_clk    (core_clk),
    .reset_n     (reset_n),
    .start_store (store_req),
    .start_load  (load_req),
    .seg_list    (seg_r),
    .bank_rdata  (bank_rdata),
    .bank_req_r  (bank_req_r),
    .busy_r      (busy),
    .data_err_r  (data_err),
    .commit_r    (eng_commit)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  a_busy_readback: assert property (reg_rd && reg_addr == nv_cfg_pkg::NV_STATE_OFF
    |=> reg_rdata_r == {7'h00, $past(busy)})
    else $error("Busy readback wrong");

  a_busy_on_pin: assert property ($rose(busy) && pin_sel_r ##1 pin_sel_r |-> first_status_out_pin)
    else $error("Status pin missed busy");

  a_pin_quiet: assert property (!pin_sel_r |=> !first_status_out_pin)
    else $error("Status pin driven while unselected");

  a_err_readback: assert property (reg_rd && reg_addr == nv_cfg_pkg::NV_ERR_OFF
    |=> reg_rdata_r[0] == $past(data_err) && reg_rdata_r[7:1] == 7'h00)
    else $error("Error readback wrong");

  a_soft_reload: assert property (load_req |=> soft_reset_r && busy ##1 !soft_reset_r)
    else $error("Soft reset did not start a reload");

  a_protect_blocks: assert property (reg_wr && reg_addr == nv_cfg_pkg::NV_CTRL2_OFF && reg_wdata[0]
    && !wr_en_r && !busy && !load_req |=> !busy)
    else $error("Protected store started");

  a_store_starts: assert property (store_req |=> busy [*2])
    else $error("Store did not start");

  a_store_selfclear: assert property (reg_rd && reg_addr == nv_cfg_pkg::NV_CTRL2_OFF |=> reg_rdata_r == 8'h00)
    else $error("Store bit did not self-clear");

  a_protect_readback: assert property (reg_wr && reg_addr == nv_cfg_pkg::NV_CTRL1_OFF ##1
    reg_rd && reg_addr == nv_cfg_pkg::NV_CTRL1_OFF |=> reg_rdata_r[0] == $past(reg_wdata[0], 2))
    else $error("Write enable readback wrong");

  a_commit_pulse: assert property (commit_req |=> commit_pulse_r)
    else $error("Commit pulse missing");

  a_commit_quiet: assert property (!commit_req && !eng_commit |=> !commit_pulse_r)
    else $error("Commit pulse without a request");

  a_commit_reads_zero: assert property (reg_rd && reg_addr == nv_cfg_pkg::COMMIT_OFF |=> reg_rdata_r == 8'h00)
    else $error("Commit bit did not read back 0");

  a_ctrl1_reserved: assert property (reg_rd && reg_addr == nv_cfg_pkg::NV_CTRL1_OFF
    |=> reg_rdata_r[7:1] == 7'h00)
    else $error("Soft reset bit did not self-clear");

  a_soft_quiet: assert property (!load_req |=> !soft_reset_r)
    else $error("Soft reset pulse without a reload");

  a_soft_refused: assert property (reg_wr && reg_addr == nv_cfg_pkg::NV_CTRL1_OFF
    && reg_wdata[nv_cfg_pkg::SOFT_RST_BIT] && boot_sel_pin |=> !soft_reset_r)
    else $error("Reload taken with boot-select high");

  // Only a reload writes the bank, and only inside its walk
  a_bank_write_busy: assert property (bank_req_r.we |-> busy)
    else $error("Bank written outside a reload");

  a_pinsel_readback: assert property (reg_rd && reg_addr == nv_cfg_pkg::PIN_SEL_OFF
    |=> reg_rdata_r == {3'h0, $past(pin_sel_r), 4'h0})
    else $error("Pin select readback wrong");

  a_pin_tracks: assert property (first_status_out_pin == $past(pin_sel_r && busy))
    else $error("Status pin does not follow busy");

  a_wr_en_hold: assert property (!(reg_wr && reg_addr == nv_cfg_pkg::NV_CTRL1_OFF) |=> $stable(wr_en_r))
    else $error("Write enable changed without a write");

  // Error bit may only move as a walk finishes
  a_err_on_finish: assert property ($changed(data_err) |-> $fell(busy))
    else $error("Error bit changed outside a walk end");

  a_idle_stays: assert property (!busy && !store_req && !load_req |=> !busy)
    else $error("Busy rose without an accepted request");

  a_seg_readback: assert property (reg_rd && in_seg
    |=> reg_rdata_r == $past(seg_r[seg_off[4:0]*8 +: 8]))
    else $error("Segment readback wrong");

  c_store_done: cover property (store_req ##[1:600] $fell(busy));
  c_load_done:  cover property (load_req ##[1:600] $fell(busy));
  c_load_error: cover property ($rose(data_err));
  c_list_commit: cover property (eng_commit);
  c_reload_refused: cover property (reg_wr && reg_addr == nv_cfg_pkg::NV_CTRL1_OFF && reg_wdata[1] && boot_sel_pin);

endmodule // nv_config_transfer_control

// ===== tb/nv_config_transfer_control_tb_top.sv
`timescale 1ns/1ps
`define CHK(nm, e, s) begin num_checks++; if ((e) !== (s)) begin n_errors++; \
  $display("[ERR] %s exp %h got %h", nm, e, s); end end
module nv_config_transfer_control_tb_top;
  typedef struct { string nm; logic [7:0] e; logic [7:0] m; } exp_note_t;
  logic                  core_clk = 1'b0;
  logic                  reset_n = 1'b0;
  logic [11:0]           reg_addr = 12'h000;
  logic                  reg_wr = 1'b0;
  logic                  reg_rd = 1'b0;
  logic [7:0]            reg_wdata = 8'h00;
  logic [7:0]            reg_rdata_r;
  logic                  boot_sel_pin = 1'b0;
  logic [7:0]            bank_rdata;
  nv_cfg_pkg::bank_req_t bank_req_r;
  logic                  first_status_out_pin;
  logic                  soft_reset_r;
  logic                  commit_pulse_r;
  logic [7:0]            bank_mem [0:4095];
  logic [7:0]            saved [0:3];
  exp_note_t             notes [$];
  exp_note_t             nt;
  logic                  rd_d = 1'b0;
  logic [31:0]           lfsr = 32'h34CD0B0D;
  int                    n_errors = 0;
  int                    num_checks = 0;
  int                    cycles = 0;
  int                    n_soft = 0;
  int                    n_commit = 0;

  nv_config_transfer_control dut_u (
    .core_clk             (core_clk),
    .reset_n              (reset_n),
    .reg_addr             (reg_addr),
    .reg_wr               (reg_wr),
    .reg_rd               (reg_rd),
    .reg_wdata            (reg_wdata),
    .reg_rdata_r          (reg_rdata_r),
    .boot_sel_pin         (boot_sel_pin),
    .bank_rdata           (bank_rdata),
    .bank_req_r           (bank_req_r),
    .first_status_out_pin (first_status_out_pin),
    .soft_reset_r         (soft_reset_r),
    .commit_pulse_r       (commit_pulse_r)
  );

  ////////////////////////////////////////////////////////////////////////
  // Buffer bank seen by the engine
  assign bank_rdata = bank_mem[bank_req_r.addr];
  always @(posedge core_clk) begin
    if (bank_req_r.we) bank_mem[bank_req_r.addr] <= bank_req_r.wdata;
  end

  initial begin
    forever #50 core_clk = ~core_clk;
  end

  function automatic logic [7:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr[7:0];
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Monitor: read data lands one cycle after the read edge
  always @(posedge core_clk) begin
    cycles++;
    if (soft_reset_r === 1'b1) n_soft++;
    if (commit_pulse_r === 1'b1) n_commit++;
    if (rd_d) begin
      nt = notes.pop_front();
      `CHK(nt.nm, nt.e & nt.m, reg_rdata_r & nt.m)
    end
    rd_d <= reg_rd;
    if (cycles > 20000) begin
      n_errors++;
      test_done();
    end
  end

  task automatic test_done();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // Each access ends with one idle cycle so strobes never retrigger in one step
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(posedge core_clk); #1;
    reg_wr = 1'b0;
    @(posedge core_clk); #1;
  endtask

  task automatic rd(input string nm, input logic [11:0] a, input logic [7:0] e, input logic [7:0] m = 8'hFF);
    notes.push_back('{nm, e, m});
    reg_addr = a;
    reg_rd = 1'b1;
    @(posedge core_clk); #1;
    reg_rd = 1'b0;
    @(posedge core_clk); #1;
  endtask

  // Pin follows busy while selected, so it marks completion
  task automatic wait_done();
    int k;
    for (k = 0; k < 10 && first_status_out_pin !== 1'b1; k++) @(posedge core_clk);
    for (k = 0; k < 3000 && first_status_out_pin !== 1'b0; k++) @(posedge core_clk);
    `CHK("busy pin", 1'b0, first_status_out_pin)
    #1;
  endtask

  // One copy segment of n bytes at 0x010, then commit, then end
  task automatic seg_list(input logic [7:0] n);
    wr(12'hA00, n - 8'h01);
    wr(12'hA01, 8'h00);
    wr(12'hA02, 8'h10);
    wr(12'hA03, nv_cfg_pkg::OP_COMMIT);
    wr(12'hA04, nv_cfg_pkg::OP_END);
  endtask

  task automatic reload();
    wr(nv_cfg_pkg::NV_CTRL1_OFF, 8'h03);
    wait_done();
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    int i;
    for (i = 0; i < 4096; i++) bank_mem[i] = rnd();
    repeat (6) @(posedge core_clk);
    #1;
    reset_n = 1'b1;
    rd("state", nv_cfg_pkg::NV_STATE_OFF, 8'h00);
    rd("err", nv_cfg_pkg::NV_ERR_OFF, 8'h00);
    rd("ctrl1", nv_cfg_pkg::NV_CTRL1_OFF, 8'h00);
    rd("ctrl2", nv_cfg_pkg::NV_CTRL2_OFF, 8'h00);
    rd("pinsel", nv_cfg_pkg::PIN_SEL_OFF, 8'h00);
    for (i = 0; i < 5; i++) rd("seg", nv_cfg_pkg::SEG_BASE_OFF + i, nv_cfg_pkg::SEG_RESET[i*8 +: 8]);
    rd("seg last", nv_cfg_pkg::SEG_LAST_OFF, 8'hFF);
    wr(12'h300, rnd());
    rd("unmapped", 12'h300, 8'h00);
    wr(nv_cfg_pkg::PIN_SEL_OFF, 8'h10);
    rd("pinsel", nv_cfg_pkg::PIN_SEL_OFF, 8'h10, 8'h10);
    // Protected store must not start
    wr(nv_cfg_pkg::NV_CTRL2_OFF, 8'h01);
    `CHK("pin protected", 1'b0, first_status_out_pin)
    rd("state protected", nv_cfg_pkg::NV_STATE_OFF, 8'h00);
    seg_list(8'h04);
    for (i = 0; i < 4; i++) saved[i] = 8'h11 << i;
    for (i = 0; i < 4; i++) bank_mem[12'h010 + i] = saved[i];
    wr(nv_cfg_pkg::NV_CTRL1_OFF, 8'h01);
    rd("ctrl1", nv_cfg_pkg::NV_CTRL1_OFF, 8'h01);
    wr(nv_cfg_pkg::NV_CTRL2_OFF, 8'h01);
    rd("state busy", nv_cfg_pkg::NV_STATE_OFF, 8'h01);
    `CHK("pin busy", 1'b1, first_status_out_pin)
    rd("ctrl2 clear", nv_cfg_pkg::NV_CTRL2_OFF, 8'h00);
    wait_done();
    rd("state done", nv_cfg_pkg::NV_STATE_OFF, 8'h00);
    for (i = 0; i < 4; i++) bank_mem[12'h010 + i] = rnd();
    // Boot-select high refuses the reload
    boot_sel_pin = 1'b1;
    wr(nv_cfg_pkg::NV_CTRL1_OFF, 8'h03);
    repeat (20) @(posedge core_clk);
    #1;
    `CHK("soft refused", 0, n_soft)
    boot_sel_pin = 1'b0;
    reload();
    `CHK("soft pulse", 1, n_soft)
    `CHK("list commit", 1, n_commit)
    for (i = 0; i < 4; i++) `CHK("restored", saved[i], bank_mem[12'h010 + i])
    rd("err good", nv_cfg_pkg::NV_ERR_OFF, 8'h00);
    rd("soft clear", nv_cfg_pkg::NV_CTRL1_OFF, 8'h00, 8'h02);
    // Short list leaves the check byte unmatched
    seg_list(8'h02);
    reload();
    rd("err bad", nv_cfg_pkg::NV_ERR_OFF, 8'h01);
    seg_list(8'h04);
    reload();
    rd("err cleared", nv_cfg_pkg::NV_ERR_OFF, 8'h00);
    i = n_commit;
    wr(nv_cfg_pkg::COMMIT_OFF, 8'h01);
    `CHK("commit one", i + 1, n_commit)
    rd("commit clear", nv_cfg_pkg::COMMIT_OFF, 8'h00);
    repeat (2) @(posedge core_clk);
    test_done();
  end
endmodule // nv_config_transfer_control_tb_top
